/* File: logic/gcs_pkg.sv */
// shared types and constants for the glitchless clock switchover
package gcs_pkg;

   // ************************************************************
   // sequencing limits, counted in target-clock edges, and the select code of the first input
   // ************************************************************
   localparam logic [2:0] DRAIN_LIMIT = 3'h3;  // target pulses before forced low
   localparam logic [2:0] PARK_EDGES  = 3'h2;  // target falling edges held low
   localparam logic [4:0] SWITCH_MAX  = 5'h11; // whole switchover, 17 cycles
   localparam logic       SEL_FIRST   = 1'h0;  // select code of first input

   // ************************************************************
   // sequencer states, one-hot
   // ************************************************************
   typedef enum logic [2:0] {
      ST_FOLLOW = 3'h1,  // output tracks the chosen clock
      ST_DRAIN  = 3'h2,  // finish the running high phase of old clock
      ST_PARK   = 3'h4   // output parked low, waiting on new clock
   } gcs_state_t;

   // ************************************************************
   // pin group sampled from outside the mclk domain
   // ************************************************************
   typedef struct packed {
      logic firstClockInput;   // first clock source level
      logic secondClockInput;  // second clock source level
      logic sourceSelect;      // 0 first input, 1 second input
      logic lowSwingGuard0;    // first input amplitude lost
      logic lowSwingGuard1;    // second input amplitude lost
      logic startupCapPin;     // high when strapped to supply
   } gcs_pins_t;

   // ************************************************************
   // complete module state
   // ************************************************************
   typedef struct packed {
      gcs_pins_t  sync1;       // first synchroniser stage
      gcs_pins_t  sync2;       // second synchroniser stage
      logic       strapTaken;  // strap captured after reset
      logic       bypass;      // runt suppression disabled
      logic       lvl0;        // last valid level of first input
      logic       lvl1;        // last valid level of second input
      logic       cur;         // index of the clock being followed
      gcs_state_t state;       // sequencer state
      logic [2:0] cnt;         // stage edge counter
      logic       out;         // true output
      logic       outN;        // complement output
   } gcs_regs_t;

endpackage

/* File: logic/gcs_switchover.sv */
// glitchless two-input clock selector sampled on mclk
module gcs_switchover (
   input  wire logic           mclk,
   input  wire logic           resetn,
   input  wire gcs_pkg::gcs_pins_t pins,
   output logic                clkOut,
   output logic                clkOutN
);

   // ************************************************************
   // state and helpers
   // ************************************************************
   gcs_pkg::gcs_regs_t regs_r;    // registered state
   gcs_pkg::gcs_regs_t regs_nxt;  // next state
   logic               eff0;      // guarded level of first input
   logic               eff1;      // guarded level of second input
   logic               curLvl;    // level of the followed clock
   logic               tgtRise;   // target clock rising edge
   logic               tgtFall;   // target clock falling edge

   // choose between the two inputs by index, used in both directions
   function automatic logic pick(input logic idx, input logic a,
                                 input logic b);
      begin
         pick = (idx == gcs_pkg::SEL_FIRST) ? a : b;
      end
   endfunction

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb
   begin
      regs_nxt = regs_r;
      // two stages before any logic looks at a pin
      regs_nxt.sync1 = pins;
      regs_nxt.sync2 = regs_r.sync1;
      // a guarded input keeps its last valid level
      eff0 = regs_r.sync2.lowSwingGuard0 ? regs_r.lvl0
                                          : regs_r.sync2.firstClockInput;
      eff1 = regs_r.sync2.lowSwingGuard1 ? regs_r.lvl1
                                          : regs_r.sync2.secondClockInput;
      regs_nxt.lvl0 = eff0;
      regs_nxt.lvl1 = eff1;
      curLvl  = pick(regs_r.cur, eff0, eff1);
      tgtRise = pick(~regs_r.cur, ~regs_r.lvl0 & eff0, ~regs_r.lvl1 & eff1);
      tgtFall = pick(~regs_r.cur, regs_r.lvl0 & ~eff0, regs_r.lvl1 & ~eff1);
      // strap is read once, after reset has been released
      if (!regs_r.strapTaken)
      begin
         regs_nxt.strapTaken = 1'b1;
         regs_nxt.bypass     = regs_r.sync2.startupCapPin;
      end
      case (regs_r.state)
         gcs_pkg::ST_FOLLOW:
         begin
            regs_nxt.out = curLvl;
            if (regs_r.bypass)
            begin
               // plain multiplexer: switch at once
               regs_nxt.cur = regs_r.sync2.sourceSelect;
               regs_nxt.out = pick(regs_r.sync2.sourceSelect, eff0, eff1);
            end
            // no switch starts until the strap has been read
            else if (regs_r.strapTaken &&
                     regs_r.sync2.sourceSelect != regs_r.cur)
            begin
               regs_nxt.cnt = 3'h0;
               // a high phase in progress is finished first
               if (curLvl)
               begin
                  regs_nxt.state = gcs_pkg::ST_DRAIN;
                  regs_nxt.out   = 1'b1;
               end
               else
               begin
                  regs_nxt.state = gcs_pkg::ST_PARK;
                  regs_nxt.out   = 1'b0;
               end
            end
         end
         gcs_pkg::ST_DRAIN:
         begin
            regs_nxt.out = 1'b1;
            if (!curLvl)
            begin
               // old clock fell naturally
               regs_nxt.state = gcs_pkg::ST_PARK;
               regs_nxt.out   = 1'b0;
               regs_nxt.cnt   = 3'h0;
            end
            else if (tgtRise)
            begin
               if (regs_r.cnt == gcs_pkg::DRAIN_LIMIT - 3'h1)
               begin
                  // old clock is stuck high: force it down
                  regs_nxt.state = gcs_pkg::ST_PARK;
                  regs_nxt.out   = 1'b0;
                  regs_nxt.cnt   = 3'h0;
               end
               else
               begin
                  regs_nxt.cnt = regs_r.cnt + 3'h1;
               end
            end
         end
         gcs_pkg::ST_PARK:
         begin
            regs_nxt.out = 1'b0;
            if (tgtFall)
            begin
               // leaving on a falling edge keeps a full low phase
               if (regs_r.cnt == gcs_pkg::PARK_EDGES - 3'h1)
               begin
                  regs_nxt.state = gcs_pkg::ST_FOLLOW;
                  regs_nxt.cur   = ~regs_r.cur;
                  regs_nxt.cnt   = 3'h0;
               end
               else
               begin
                  regs_nxt.cnt = regs_r.cnt + 3'h1;
               end
            end
         end
         default:
         begin
            regs_nxt.state = gcs_pkg::ST_FOLLOW;
            regs_nxt.cnt   = 3'h0;
         end
      endcase
      regs_nxt.outN = ~regs_nxt.out;
   end

   // ************************************************************
   // state register, synchronous reset
   // ************************************************************
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         regs_r       <= '0;
         regs_r.state <= gcs_pkg::ST_FOLLOW;
         regs_r.outN  <= 1'b1;
         // synchronisers keep filling, so the strap is valid at release
         regs_r.sync1 <= pins;
         regs_r.sync2 <= regs_r.sync1;
      end
      else
      begin
         regs_r <= regs_nxt;
      end
   end

   assign clkOut  = regs_r.out;
   assign clkOutN = regs_r.outN;

   // ************************************************************
   // checks
   // ************************************************************
   logic [4:0] swCnt_r;  // target falling edges during a switchover

   // counts how long a switchover lasts in target cycles
   always_ff @(posedge mclk)
   begin
      if (!resetn || regs_r.state == gcs_pkg::ST_FOLLOW)
         swCnt_r <= 5'h0;
      else if (tgtFall && swCnt_r != 5'h1f)
         swCnt_r <= swCnt_r + 5'h1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // complement is a register of its own, so it is watched separately
   a_out_complement: assert property (
      clkOutN == ~clkOut)
      else $error("complement output not inverse of true output");
   a_park_low: assert property (
      regs_r.state == gcs_pkg::ST_PARK |-> !clkOut)
      else $error("output not low while parked");
   a_drain_high: assert property (
      regs_r.state == gcs_pkg::ST_DRAIN |-> clkOut)
      else $error("output not high while finishing old phase");
   a_drain_bound: assert property (
      regs_r.state == gcs_pkg::ST_DRAIN |->
         regs_r.cnt < gcs_pkg::DRAIN_LIMIT)
      else $error("stuck-high hold exceeded its pulse count");
   a_switch_total: assert property (
      swCnt_r <= gcs_pkg::SWITCH_MAX)
      else $error("switchover took more than seventeen cycles");
   a_park_exit: assert property (
      $fell(regs_r.state == gcs_pkg::ST_PARK) |->
         $past(regs_r.cnt) == gcs_pkg::PARK_EDGES - 3'h1 && !clkOut)
      else $error("park left before enough target edges");
   a_swap_index: assert property (
      $fell(regs_r.state == gcs_pkg::ST_PARK) |->
         regs_r.cur != $past(regs_r.cur))
      else $error("followed input not swapped at end of switchover");
   a_bypass_plain: assert property (
      regs_r.bypass |-> regs_r.state == gcs_pkg::ST_FOLLOW ##1
         regs_r.cur == $past(regs_r.sync2.sourceSelect))
      else $error("bypass did not switch immediately");
   a_guard_freeze: assert property (
      regs_r.state == gcs_pkg::ST_FOLLOW && !regs_r.bypass &&
         (regs_r.cur ? regs_r.sync2.lowSwingGuard1
                     : regs_r.sync2.lowSwingGuard0) &&
         regs_r.sync2.sourceSelect == regs_r.cur |=> $stable(clkOut))
      else $error("output moved while input amplitude was lost");
   a_sel_sync: assert property (
      $changed(regs_r.sync2.sourceSelect) |->
         regs_r.sync2.sourceSelect == $past(regs_r.sync1.sourceSelect))
      else $error("select reached logic without two stages");

   // main scenarios: normal drain, forced drop, bypass, frozen input
   c_normal_switch: cover property (
      regs_r.state == gcs_pkg::ST_DRAIN ##1 regs_r.state == gcs_pkg::ST_PARK);
   c_forced_low: cover property (
      regs_r.state == gcs_pkg::ST_DRAIN && tgtRise && curLvl &&
         regs_r.cnt == gcs_pkg::DRAIN_LIMIT - 3'h1);
   c_bypass_on: cover property (regs_r.bypass && $changed(regs_r.cur));
   c_guard_hold: cover property (
      regs_r.sync2.lowSwingGuard1 && regs_r.cur != gcs_pkg::SEL_FIRST);

endmodule

/* File: tb/gcs_sources.sv */
// partner model: two free-running source clocks that can be frozen
module gcs_sources #(
   parameter int HALF0 = 5,  // half period of first source, mclk cycles
   parameter int HALF1 = 6   // half period of second source, mclk cycles
) (
   input  wire logic mclk,
   input  wire logic stuck0,
   input  wire logic stuck1,
   output logic      clk0,
   output logic      current_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt0 = 0;  // phase counter, first source
   int cnt1 = 0;  // phase counter, second source
   initial
   begin
      clk0 = 1'h0;
      current_clock = 1'h0;
   end
   // ************************************************************
   // sources, periods 10 and 12 keep within the allowed ratio
   // ************************************************************
   // a frozen source keeps its level, like a failed oscillator
   always @(posedge mclk)
   begin
      cnt0 = (cnt0 + 1) % HALF0;
      cnt1 = (cnt1 + 1) % HALF1;
      if (cnt0 == 0 && !stuck0)
         clk0 <= ~clk0;
      if (cnt1 == 0 && !stuck1)
         current_clock <= ~current_clock;
   end
endmodule

/* File: tb/gcs_switchover_bench.sv */
// self-checking bench for the glitchless clock switchover
module gcs_switchover_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int H0 = 5;  // first source half period
   localparam int H1 = 6;  // second source half period
   logic mclk = 1'h0;
   logic resetn = 1'h0;
   gcs_pkg::gcs_pins_t pins = '0;
   logic clkOut;
   logic clkOutN;
   logic sel = 1'h0;
   logic g0 = 1'h0;
   logic g1 = 1'h0;
   logic strap = 1'h0;
   logic stuck0 = 1'h0;
   logic stuck1 = 1'h0;
   logic clk0;
   logic current_clock;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   always #5 mclk = ~mclk;
   gcs_sources #(.HALF0(H0), .HALF1(H1)) src (.mclk(mclk), .stuck0(stuck0),
      .stuck1(stuck1), .clk0(clk0), .current_clock(current_clock));
   gcs_switchover dut (.mclk(mclk), .resetn(resetn), .pins(pins),
      .clkOut(clkOut), .clkOutN(clkOutN));
   // pins change just after the edge, like any asynchronous source
   always @(posedge mclk)
   begin
      pins.firstClockInput <= clk0;
      pins.secondClockInput <= current_clock;
      pins.sourceSelect <= sel;
      pins.lowSwingGuard0 <= g0;
      pins.lowSwingGuard1 <= g1;
      pins.startupCapPin <= strap;
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   // ************************************************************
   // compare and measure helpers
   // ************************************************************
   task automatic chkBit(logic got, logic exp, string what);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask
   task automatic chkRange(int got, int lo, int hi, string what);
      n_checks++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("ERROR %0t %s %0d", $time, what, got);
      end
   endtask
   // one low run then one high run of clkOut, in mclk cycles
   task automatic measure(output int lo, output int hi);
      lo = 0;
      hi = 0;
      // never look at the output in the step of the edge that moves it
      #1;
      while (clkOut !== 1'h1 && lo < 400)
      begin
         @(posedge mclk);
         #1 lo++;
      end
      while (clkOut === 1'h1 && hi < 400)
      begin
         @(posedge mclk);
         #1 hi++;
      end
   endtask
   task automatic doReset(logic s);
      @(posedge mclk);
      resetn <= 1'h0;
      strap <= s;
      sel <= 1'h0;
      stuck0 <= 1'h0;
      repeat (10) @(posedge mclk);
      #1 chkBit(clkOut, 1'h0, "reset level");
      chkBit(clkOutN, 1'h1, "reset complement");
      @(posedge mclk);
      resetn <= 1'h1;
      repeat (6) @(posedge mclk);
      $display("test reset done");
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic tFollow();
      int lo, hi;
      measure(lo, hi);
      measure(lo, hi);
      chkRange(hi, H0, H0, "first input phase");
      chkBit(clkOutN, ~clkOut, "complement");
      $display("test follow done");
   endtask
   // no runt phase on the way, new clock within the bound
   task automatic tSwitch(logic s, int h);
      int lo, hi, el, k;
      el = 0;
      k = 0;
      @(posedge mclk);
      sel <= s;
      do
      begin
         measure(lo, hi);
         el += lo + hi;
         if (k > 0)
            chkRange(lo < hi ? lo : hi, H0, 400, "runt phase");
         else
            chkRange(hi, h / 2 + 1, 400, "stretched high");
         k++;
      end while (hi != h && k < 40);
      chkRange(lo, h / 2 + 1, 400, "stretched low");
      chkRange(el, 1, 36 * h + 8, "switch time");
      measure(lo, hi);
      chkRange(hi, h, h, "target phase");
      $display("test switch to %0d done", s);
   endtask
   task automatic tStuckHigh();
      @(posedge clk0);
      stuck0 <= 1'h1;
      repeat (12) @(posedge mclk);
      tSwitch(1'h1, H1);
      @(posedge mclk);
      stuck0 <= 1'h0;
      $display("test stuck high done");
   endtask
   task automatic tGuard();
      int ch;
      logic v;
      ch = 0;
      g1 <= 1'h1;
      repeat (4) @(posedge mclk);
      #1 v = clkOut;
      repeat (40)
      begin
         @(posedge mclk);
         #1 if (clkOut !== v) ch++;
      end
      chkRange(ch, 0, 0, "frozen output");
      @(posedge mclk);
      g1 <= 1'h0;
      $display("test guard done");
   endtask
   // plain multiplexer: old stuck high, output low within 2 * H1 + 4 mclk cycles
   task automatic tBypass();
      int t;
      t = 0;
      @(posedge clk0);
      stuck0 <= 1'h1;
      repeat (12) @(posedge mclk);
      sel <= 1'h1;
      while (clkOut !== 1'h0 && t < 100)
      begin
         @(posedge mclk);
         #1 t++;
      end
      chkRange(t, 1, 2 * H1 + 4, "bypass switch");
      $display("test bypass done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      doReset(1'h0);
      tFollow();
      tSwitch(1'h1, H1);
      tSwitch(1'h0, H0);
      tStuckHigh();
      tGuard();
      doReset(1'h1);
      tBypass();
      summarize();
   end
endmodule
